// File: gpe_port_map.vh
// Constants for the eight-pin port with external interrupt
`ifndef GPE_PORT_MAP_VH
`define GPE_PORT_MAP_VH
`define GPE_PINS 8
`define GPE_VECTORS 2
`define GPE_DIR_RESET 8'h00
`define GPE_DATA_RESET 8'h00
`define GPE_OPT_RESET 8'h00
`define GPE_SENSE_RESET 2'h0
`define GPE_COMB_RESET 1'h1
`define GPE_SENSE_FALL 1'h0
`define GPE_SENSE_RISE 1'h1
`define GPE_VEC0_MASK 8'h0F
`define GPE_VEC1_MASK 8'hF0
`endif

// File: gpe_port.v
// Eight-pin bidirectional port with per-vector external interrupt edge detection
`timescale 1ns/1ps
`include "gpe_port_map.vh"

module gpe_port
(
  // Clock and reset
  input wire sysClk,
  input wire resetn,
  input wire clkEn,
  // Register writes from the CPU
  input wire dirWrite,
  input wire [7:0] dirWdata,
  input wire dataWrite,
  input wire [7:0] dataWdata,
  input wire optWrite,
  input wire [7:0] optWdata,
  input wire senseWrite,
  input wire [1:0] senseWdata,
  // CPU status
  input wire irqMaskBit,
  input wire [1:0] vectorFetch,
  input wire lowPowerMode,
  // Alternate functions
  input wire [7:0] altOutEn,
  input wire [7:0] altOutValue,
  output reg [7:0] altInValue,
  // Pins
  input wire [7:0] pinIn,
  output reg [7:0] pinOut,
  output reg [7:0] pinOe,
  output reg [7:0] pinPullUp,
  // Register readback and interrupt
  output reg [7:0] pinDirectionBit,
  output reg [7:0] pinOptionBit,
  output reg [1:0] extIrqSenseCtrl,
  output reg [7:0] portDataRead,
  output reg [1:0] irqPending,
  output reg [1:0] irqRequest,
  output reg wakeUp
);

  // ---------------------------------------------------------------
  // Latches and synchroniser
  // ---------------------------------------------------------------
  reg [7:0] portDataLatchReg;
  reg [7:0] pinMeta;
  reg [7:0] pinSync;
  wire [7:0] irqPinEn;
  wire [7:0] detIn;
  wire [1:0] edgeHit;
  wire [1:0] senseClr;
  wire [7:0] altForce;
  reg [1:0] next_pending;
  reg [7:0] next_oe;
  reg [7:0] next_out;
  reg [7:0] next_read;
  integer i;

  always @(posedge sysClk or negedge resetn)
  begin
    if (!resetn)
    begin
      pinMeta <= 8'h00;
      pinSync <= 8'h00;
    end
    else if (clkEn)
    begin
      pinMeta <= pinIn;
      pinSync <= pinMeta;
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  always @(posedge sysClk or negedge resetn)
  begin
    if (!resetn)
    begin
      pinDirectionBit <= `GPE_DIR_RESET;
    end
    else if (clkEn && dirWrite)
    begin
      pinDirectionBit <= dirWdata;
    end
  end

  // Written in any mode; an input pin never sees the latch
  always @(posedge sysClk or negedge resetn)
  begin
    if (!resetn)
    begin
      portDataLatchReg <= `GPE_DATA_RESET;
    end
    else if (clkEn && dataWrite)
    begin
      portDataLatchReg <= dataWdata;
    end
  end

  always @(posedge sysClk or negedge resetn)
  begin
    if (!resetn)
    begin
      pinOptionBit <= `GPE_OPT_RESET;
    end
    else if (clkEn && optWrite)
    begin
      pinOptionBit <= optWdata;
    end
  end

  always @(posedge sysClk or negedge resetn)
  begin
    if (!resetn)
    begin
      extIrqSenseCtrl <= `GPE_SENSE_RESET;
    end
    else if (clkEn && senseWrite)
    begin
      extIrqSenseCtrl <= senseWdata;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt detection
  // ---------------------------------------------------------------
  // Pins 0-3 share vector 0, pins 4-7 vector 1
  assign irqPinEn = ~pinDirectionBit & pinOptionBit;
  assign detIn = pinSync | ~irqPinEn;
  // Sensitivity changes are not edges: a write that changes a vector's sense clears its pending flag
  assign senseClr = senseWrite ? (senseWdata ^ extIrqSenseCtrl) : 2'h0;

  // ---------------------------------------------------------------
  // Vector edge detectors
  // ---------------------------------------------------------------
  // One detector per vector, each gating only its own pin group
  gpe_vec_det
  #(
    .GROUP(`GPE_VEC0_MASK)
  )
  u_gpe_vec_det0
  (
    .sysClk(sysClk),
    .resetn(resetn),
    .clkEn(clkEn),
    .detIn(detIn),
    .senseRise(extIrqSenseCtrl[0]),
    .edgeHit(edgeHit[0])
  );

  gpe_vec_det
  #(
    .GROUP(`GPE_VEC1_MASK)
  )
  u_gpe_vec_det1
  (
    .sysClk(sysClk),
    .resetn(resetn),
    .clkEn(clkEn),
    .detIn(detIn),
    .senseRise(extIrqSenseCtrl[1]),
    .edgeHit(edgeHit[1])
  );

  always @*
  begin
    // A new edge wins over a fetch clear so no event is lost
    next_pending = (irqPending & ~vectorFetch & ~senseClr) | edgeHit;
  end

  always @(posedge sysClk or negedge resetn)
  begin
    if (!resetn)
    begin
      irqPending <= 2'h0;
      irqRequest <= 2'h0;
    end
    else if (clkEn)
    begin
      irqPending <= next_pending;
      irqRequest <= irqMaskBit ? 2'h0 : next_pending;
    end
  end

  // Wake-up follows the same pending term so it never lags the request
  always @(posedge sysClk or negedge resetn)
  begin
    if (!resetn)
    begin
      wakeUp <= 1'b0;
    end
    else if (clkEn)
    begin
      wakeUp <= lowPowerMode & ~irqMaskBit & (|next_pending);
    end
  end

  // ---------------------------------------------------------------
  // Pin drive, readback and alternate functions
  // ---------------------------------------------------------------
  assign altForce = altOutEn;

  always @*
  begin
    next_oe = 8'h00;
    next_out = 8'h00;
    next_read = 8'h00;
    for (i = 0; i < `GPE_PINS; i = i + 1)
    begin
      if (altForce[i])
      begin
        next_oe[i] = 1'b1;
        next_out[i] = altOutValue[i];
      end
      else if (pinDirectionBit[i])
      begin
        // Open drain enables the driver only for a low level
        next_oe[i] = pinOptionBit[i] | ~portDataLatchReg[i];
        next_out[i] = portDataLatchReg[i];
      end
      if (pinDirectionBit[i])
        next_read[i] = portDataLatchReg[i];
      else if (altOutEn[i])
        next_read[i] = altOutValue[i];
      else
        next_read[i] = pinSync[i];
    end
  end

  // Port state is never touched by low power entry
  always @(posedge sysClk or negedge resetn)
  begin
    if (!resetn)
    begin
      pinOut <= 8'h00;
      pinOe <= 8'h00;
      pinPullUp <= 8'h00;
      portDataRead <= 8'h00;
      altInValue <= 8'h00;
    end
    else if (clkEn)
    begin
      pinOut <= next_out;
      pinOe <= next_oe;
      pinPullUp <= ~pinDirectionBit & pinOptionBit & ~altOutEn;
      portDataRead <= next_read;
      altInValue <= (pinDirectionBit & portDataLatchReg) | (~pinDirectionBit & pinSync);
    end
  end

endmodule

// Combining gate and edge detector for one interrupt vector
module gpe_vec_det
#(
  parameter [7:0] GROUP = 8'hFF
)
(
  // Clock and reset
  input wire sysClk,
  input wire resetn,
  input wire clkEn,
  // Gated pin levels, disabled pins already forced high
  input wire [7:0] detIn,
  // Sensitivity, high for rising
  input wire senseRise,
  // Edge seen this cycle
  output wire edgeHit
);

  // ---------------------------------------------------------------
  // Combining gate and edge detector
  // ---------------------------------------------------------------
  wire comb;
  reg combPrev;

  // One low pin of the group holds the combined level low
  assign comb = &(detIn | ~GROUP);
  assign edgeHit = senseRise ? (comb & ~combPrev) : (~comb & combPrev);

  always @(posedge sysClk or negedge resetn)
  begin
    if (!resetn)
    begin
      // Idle level of the gate is high, so leaving reset makes no edge
      combPrev <= `GPE_COMB_RESET;
    end
    else if (clkEn)
    begin
      combPrev <= comb;
    end
  end

endmodule

// File: gpe_port_assertions.sv
// Checker for the eight-pin port
`timescale 1ns/1ps
module gpe_port_assertions (
  input wire sysClk, resetn, clkEn, irqMaskBit, lowPowerMode, senseWrite, wakeUp,
  input wire [1:0] vectorFetch, irqPending, irqRequest,
  input wire [7:0] altOutEn, pinOe, pinOut, pinPullUp, pinDirectionBit, pinOptionBit
);
  // Frozen cycles are skipped; state does not move then
  default clocking cb @(posedge sysClk);
  endclocking
  default disable iff (!resetn || !clkEn);
  a_mask_blocks: assert property ($past(irqMaskBit) |-> irqRequest == 2'h0)
    else $error("request while masked");
  a_wake_cause: assert property (wakeUp |-> $past(lowPowerMode) && !$past(irqMaskBit))
    else $error("wake without cause");
  a_pend_hold: assert property ($fell(irqPending[0]) |-> $past(vectorFetch[0] | senseWrite))
    else $error("pending lost");
  a_pullup_cfg: assert property ((pinPullUp & ~$past(~pinDirectionBit & pinOptionBit)) == 8'h00)
    else $error("pull-up misplaced");
  a_input_undriven: assert property ((pinOe & ~$past(pinDirectionBit | altOutEn)) == 8'h00)
    else $error("input driven");
  a_od_high: assert property
    ((pinOe & pinOut & $past(pinDirectionBit & ~pinOptionBit & ~altOutEn)) == 8'h00)
    else $error("open drain high");
  a_pp_drives: assert property ((~pinOe & $past(pinDirectionBit & pinOptionBit)) == 8'h00)
    else $error("push-pull idle");
  a_alt_forces: assert property ((~pinOe & $past(altOutEn)) == 8'h00)
    else $error("alternate not driven");
endmodule
bind gpe_port gpe_port_assertions u_gpe_port_assertions (.*);

// File: gpe_pin_model.sv
// Pin model: port, outside drivers and pull-ups meeting on each pin
`timescale 1ns/1ps
module gpe_pin_model (
  input wire clk,
  input wire [7:0] drvOut, drvOe, pullUp, extLevel, extOe,
  output reg [7:0] pinIn
);
  // A floating pin toggles, so a read of it never looks valid by chance
  initial pinIn = 8'h00;
  always @(posedge clk)
    pinIn <= (drvOe & drvOut) | (~drvOe & extOe & extLevel)
      | (~drvOe & ~extOe & (pullUp | ~pinIn));
endmodule

// File: gpe_port_tb_top.sv
// Testbench for the eight-pin port
`timescale 1ns/1ps
module gpe_port_tb_top;
  reg sysClk = 1'h0, resetn = 1'h0, clkEn = 1'h1, irqMaskBit = 1'h1, lowPowerMode = 1'h0;
  reg dirWrite = 1'h0, dataWrite = 1'h0, optWrite = 1'h0, senseWrite = 1'h0;
  reg [1:0] senseWdata = 2'h0, vectorFetch = 2'h0;
  reg [7:0] dirWdata = 8'h00, dataWdata = 8'h00, optWdata = 8'h00, altOutEn = 8'h00;
  reg [7:0] altOutValue = 8'h00, extLevel = 8'h00, extOe = 8'h00;
  wire [7:0] pinIn, pinOut, pinOe, pinPullUp, pinDirectionBit, pinOptionBit, portDataRead;
  wire [7:0] altInValue;
  wire [1:0] extIrqSenseCtrl, irqPending, irqRequest;
  wire wakeUp;
  int failures = 0, cmpCount = 0;
  always #4 sysClk = ~sysClk;
  gpe_port u_gpe_port (.*);
  gpe_pin_model u_gpe_pin_model (.clk(sysClk), .drvOut(pinOut), .drvOe(pinOe),
    .pullUp(pinPullUp), .extLevel(extLevel), .extOe(extOe), .pinIn(pinIn));
  task w(input int n);
    repeat (n) @(posedge sysClk);
  endtask
  // Kind 0 direction, 1 data, 2 option, 3 sensitivity
  task wr(input int k, input [7:0] v);
    @(posedge sysClk);
    {dirWdata, dataWdata, optWdata, senseWdata} <= {v, v, v, v[1:0]};
    {dirWrite, dataWrite, optWrite, senseWrite} <= 4'h8 >> k;
    @(posedge sysClk);
    {dirWrite, dataWrite, optWrite, senseWrite} <= 4'h0;
  endtask
  task chk(input string s, input [7:0] e, input [7:0] g);
    cmpCount++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  task print_verdict;
    $display("compares %0d mismatches %0d", cmpCount, failures);
    if (failures == 0 && cmpCount > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    failures++;
    print_verdict;
  end
  initial
  begin
    w(20);
    resetn <= 1'h1;
    wr(0, 8'hFF);
    wr(2, 8'h0F);
    wr(1, 8'hA5);
    w(3);
    chk("oe", 8'h5F, pinOe);
    chk("drive", 8'h05, pinOut & pinOe);
    chk("read", 8'hA5, portDataRead);
    chk("altin", 8'hA5, altInValue);
    $display("test 1 done");
    {extOe, extLevel, altOutEn, altOutValue} <= {8'hFE, 8'h3C, 8'h01, 8'h01};
    wr(0, 8'h00);
    wr(1, 8'h5A);
    wr(2, 8'h04);
    w(5);
    chk("oe", 8'h01, pinOe);
    chk("read", 8'h3D, portDataRead);
    chk("pullup", 8'h04, pinPullUp);
    chk("altin", 8'h3D, altInValue);
    $display("test 2 done");
    {extOe, extLevel, altOutEn} <= {8'hFF, 8'hFF, 8'h00};
    wr(3, 8'h03);
    wr(2, 8'h03);
    wr(3, 8'h00);
    irqMaskBit <= 1'h0;
    extLevel <= 8'hFD;
    w(6);
    chk("request", 8'h01, {6'h0, irqRequest});
    vectorFetch <= 2'h1;
    w(1);
    vectorFetch <= 2'h0;
    extLevel <= 8'hFC;
    w(4);
    extLevel <= 8'hFF;
    w(6);
    chk("pending", 8'h00, {6'h0, irqPending});
    extLevel <= 8'hFE;
    w(6);
    chk("pending", 8'h01, {6'h0, irqPending});
    wr(3, 8'h01);
    w(2);
    chk("pending", 8'h00, {6'h0, irqPending});
    {extLevel, irqMaskBit, lowPowerMode} <= {8'hFF, 1'h1, 1'h1};
    w(6);
    chk("request", 8'h00, {6'h0, irqRequest});
    irqMaskBit <= 1'h0;
    w(3);
    chk("wake", 8'h01, {7'h0, wakeUp});
    {vectorFetch, lowPowerMode} <= {2'h1, 1'h0};
    w(1);
    {vectorFetch, extLevel} <= {2'h0, 8'hFD};
    w(6);
    wr(2, 8'h01);
    w(6);
    chk("spurious", 8'h01, {6'h0, irqPending});
    $display("test 3 done");
    clkEn <= 1'h0;
    wr(0, 8'hFF);
    w(2);
    chk("frozen dir", 8'h00, pinDirectionBit);
    chk("frozen pending", 8'h01, {6'h0, irqPending});
    clkEn <= 1'h1;
    w(2);
    chk("thawed dir", 8'h00, pinDirectionBit);
    $display("test 4 done");
    print_verdict;
  end
endmodule
